// ===== core/poll_addr_pkg.sv
// shared constants, states and carriers for the poll and address status block
package poll_addr_pkg;
  // register offsets, both registers live at printed addresses
  localparam logic [11:0] POLL_STATUS_OFS = 12'h117;
  localparam logic [11:0] ADDRESS_STATE_OFS = 12'h119;
  // poll status byte field positions
  localparam int STATUS_TOP_POS = 7;
  localparam int REQ_POS = 6;
  localparam logic [7:0] POLL_STATUS_RESET = 8'h00;
  // address state byte field positions
  localparam int ADS_CTRL_POS = 7;
  localparam int ADS_ATN_POS = 6;
  localparam int ADS_POLL_POS = 5;
  localparam int ADS_LPRI_POS = 4;
  localparam int ADS_TPRI_POS = 3;
  localparam int ADS_LISTEN_POS = 2;
  localparam int ADS_TALK_POS = 1;
  localparam int ADS_MINOR_POS = 0;
  // addressing modes
  localparam logic [1:0] MODE_ONLY = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_EXT_SINGLE = 2'h2;
  localparam logic [1:0] MODE_EXT_DUAL = 2'h3;
  // bus command codes, seven bit
  localparam logic [6:0] CMD_POLL_ENABLE = 7'h18;
  localparam logic [6:0] CMD_POLL_DISABLE = 7'h19;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3f;
  localparam logic [6:0] CMD_UNTALK = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam logic [4:0] ADDR_RESERVED = 5'h1f;

  // service request states, one-hot
  typedef enum logic [2:0] {
    SR_NEG = 3'b001,
    SR_REQ = 3'b010,
    SR_AFF = 3'b100
  } sr_state_e;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // addressing configuration from the mode and address registers
  typedef struct packed {
    logic [1:0] mode;
    logic talk_only;
    logic listen_only;
    logic [4:0] major_addr;
    logic [4:0] minor_addr;
    logic [4:0] second_addr;
  } addr_cfg_s;
endpackage : poll_addr_pkg

// ===== core/poll_addr_status.sv
// serial poll response and address status logic of the bus interface chip
// Operation
// - status top and low bits clear on reset
// - send poll byte to listening controller
// - request set and not polled asserts SRQ
// - request bit clears on affirmative poll, reset
// - outstanding flag set on write, cleared after send
// - controller role reads inverse idle-or-addressed
// - attention status bit shows live ATN level
// - poll mode set by SPE while talker addressed, cleared SPD/resets
// - listen primary seen in extended addressing
// - talk primary seen in extended addressing
// - receiver addressed bit shows listener states
// - speaker addressed bit shows talker states
// - talk and listen addressing exclude each other, except in the programmed only mode
// - minor flag follows minor/major address received
// - minor flag zero outside dual primary modes
// - mode 2 needs primary then secondary
`timescale 1ns/1ps
module poll_addr_status (
  input wire logic mclk,
  input wire logic rst_n,
  input poll_addr_pkg::reg_req_s reg_req,
  output logic [7:0] rd_data,
  input wire logic chip_reset,
  input wire logic soft_reset_bit,
  input poll_addr_pkg::addr_cfg_s addr_cfg,
  input wire logic ctrl_idle,
  input wire logic ctrl_addressed,
  input wire logic atn_n_pin,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_byte,
  input wire logic sec_accept,
  input wire logic sec_reject,
  input wire logic poll_byte_taken,
  output logic [7:0] poll_byte,
  output logic poll_byte_valid,
  output logic srq_oe
);
  import poll_addr_pkg::*;

  // synchroniser for the bus attention pin
  logic atn_meta_reg;
  logic atn_n_reg;
  // stored poll status bits, request bit and outstanding flag
  logic [7:0] status_reg;
  logic rsv_reg;
  logic outstanding_reg;
  sr_state_e sr_reg;
  sr_state_e sr_next;
  // address state flags
  logic speaker_reg;
  logic receiver_reg;
  logic poll_mode_reg;
  logic listen_prim_reg;
  logic talk_prim_reg;
  logic minor_reg;
  logic prim_minor_reg; // which primary matched while waiting for a secondary
  logic [7:0] rd_data_reg;
  logic poll_valid_reg;
  logic srq_reg;

  // any hard clear: power-up handled by rst_n, chip reset command here
  wire logic hard_clr = chip_reset;
  wire logic soft_clr = chip_reset | soft_reset_bit;

  // register port decode
  wire logic sel_poll = reg_req.addr == POLL_STATUS_OFS;
  wire logic sel_ads = reg_req.addr == ADDRESS_STATE_OFS;
  wire logic wr_poll = reg_req.wr & sel_poll;
  wire logic wr_rsv_set = wr_poll & reg_req.wdata[REQ_POS];

  // command decode, bit 7 of the byte is parity and ignored
  wire logic [6:0] cmd7 = cmd_byte[6:0];
  wire logic [1:0] grp = cmd7[6:5];
  wire logic [4:0] cad = cmd7[4:0];
  wire logic is_listen = cmd_strobe & (grp == GRP_LISTEN) & (cad != ADDR_RESERVED);
  wire logic is_talk = cmd_strobe & (grp == GRP_TALK) & (cad != ADDR_RESERVED);
  wire logic is_sec = cmd_strobe & (grp == GRP_SECONDARY) & (cad != ADDR_RESERVED);
  wire logic is_primary = cmd_strobe & (grp != GRP_SECONDARY);
  wire logic is_unl = cmd_strobe & (cmd7 == CMD_UNLISTEN);
  wire logic is_unt = cmd_strobe & (cmd7 == CMD_UNTALK);
  wire logic is_spe = cmd_strobe & (cmd7 == CMD_POLL_ENABLE);
  wire logic is_spd = cmd_strobe & (cmd7 == CMD_POLL_DISABLE);

  // mode qualifiers
  wire logic mode_dual = addr_cfg.mode == MODE_DUAL;
  wire logic mode_ext1 = addr_cfg.mode == MODE_EXT_SINGLE;
  wire logic mode_ext3 = addr_cfg.mode == MODE_EXT_DUAL;
  wire logic mode_only = addr_cfg.mode == MODE_ONLY;
  wire logic dual_prim = mode_dual | mode_ext3; // minor address only honoured here
  wire logic extended = mode_ext1 | mode_ext3;
  wire logic hit_major = cad == addr_cfg.major_addr;
  wire logic hit_minor = dual_prim & (cad == addr_cfg.minor_addr);
  wire logic hit_any = hit_major | hit_minor;

  // primary address matches
  wire logic my_listen = is_listen & hit_any;
  wire logic my_talk = is_talk & hit_any;
  wire logic other_talk = is_talk & ~hit_any;

  // secondary outcome: mode 2 compares, mode 3 waits for software verdict
  wire logic sec_ok2 = is_sec & mode_ext1 & (cad == addr_cfg.second_addr);
  wire logic sec_ok = sec_ok2 | (mode_ext3 & sec_accept);
  wire logic set_receiver = mode_dual ? my_listen : (sec_ok & listen_prim_reg);
  wire logic set_speaker = mode_dual ? my_talk : (sec_ok & talk_prim_reg);
  // extended talker drops when another primary talk address passes or a foreign secondary follows
  wire logic sec_miss = (is_sec & mode_ext1 & ~sec_ok2) | (mode_ext3 & sec_reject);
  wire logic drop_ext = extended & (other_talk | (talk_prim_reg & sec_miss));
  wire logic drop_speaker = is_unt | (mode_dual & other_talk) | drop_ext;

  // live bus conditions after synchronisation
  wire logic atn_active = ~atn_n_reg;
  wire logic spas = speaker_reg & poll_mode_reg & ~atn_active; // controller in standby, device talking the poll

  // service request state machine
  always_comb begin
    sr_next = sr_reg;
    unique case (sr_reg)
      SR_NEG: begin
        if (rsv_reg & ~spas) begin
          sr_next = SR_REQ;
        end
      end
      SR_REQ: begin
        if (spas & poll_byte_taken) begin
          sr_next = SR_AFF; // controller read the byte while we asked
        end else if (~rsv_reg & ~spas) begin
          sr_next = SR_NEG;
        end
      end
      SR_AFF: begin
        if (~spas) begin
          sr_next = SR_NEG;
        end
      end
    endcase
  end

  // attention pin two-stage synchroniser, first stage read by the second only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      atn_meta_reg <= 1'b1;
      atn_n_reg <= 1'b1;
    end else begin
      atn_meta_reg <= atn_n_pin;
      atn_n_reg <= atn_meta_reg;
    end
  end

  // poll status byte storage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= POLL_STATUS_RESET;
    end else if (hard_clr) begin
      status_reg <= POLL_STATUS_RESET;
    end else if (wr_poll) begin
      status_reg <= reg_req.wdata;
    end
  end

  // request bit: a write of one wins over the affirmative clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsv_reg <= 1'b0;
    end else if (hard_clr) begin
      rsv_reg <= 1'b0;
    end else if (wr_poll) begin
      rsv_reg <= reg_req.wdata[REQ_POS];
    end else if (sr_next == SR_AFF && sr_reg != SR_AFF) begin
      rsv_reg <= 1'b0;
    end
  end

  // outstanding flag, set on the write, cleared once back in negative state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outstanding_reg <= 1'b0;
    end else if (hard_clr) begin
      outstanding_reg <= 1'b0;
    end else if (wr_rsv_set) begin
      outstanding_reg <= 1'b1;
    end else if (sr_reg == SR_NEG && !rsv_reg) begin
      outstanding_reg <= 1'b0;
    end
  end

  // service request state register and its registered line drive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg <= SR_NEG;
      srq_reg <= 1'b0;
    end else if (hard_clr) begin
      sr_reg <= SR_NEG;
      srq_reg <= 1'b0;
    end else begin
      sr_reg <= sr_next;
      // the line is released as soon as the poll is active, the byte then carries the request
      srq_reg <= (sr_next == SR_REQ) & ~spas;
    end
  end

  // poll byte presented while serial poll active, bit 6 carries the request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      poll_valid_reg <= 1'b0;
    end else begin
      poll_valid_reg <= spas & ~hard_clr;
    end
  end

  // poll mode flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      poll_mode_reg <= 1'b0;
    end else if (soft_clr | is_spd) begin
      poll_mode_reg <= 1'b0;
    end else if (is_spe & speaker_reg) begin
      poll_mode_reg <= 1'b1;
    end
  end

  // primary seen flags; any other primary command cancels the wait
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      listen_prim_reg <= 1'b0;
      talk_prim_reg <= 1'b0;
      prim_minor_reg <= 1'b0;
    end else if (soft_clr | ~extended) begin
      listen_prim_reg <= 1'b0;
      talk_prim_reg <= 1'b0;
      prim_minor_reg <= 1'b0;
    end else if (is_primary) begin
      listen_prim_reg <= my_listen;
      talk_prim_reg <= my_talk;
      prim_minor_reg <= ~hit_major & hit_minor;
    end
  end

  // listener and talker addressed flags, mutually exclusive outside the programmed only mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_reg <= 1'b0;
      speaker_reg <= 1'b0;
    end else if (hard_clr) begin
      receiver_reg <= 1'b0;
      speaker_reg <= 1'b0;
    end else if (mode_only) begin
      // programmed only modes hold once set; clearing the bit alone does not leave
      receiver_reg <= receiver_reg | addr_cfg.listen_only;
      speaker_reg <= speaker_reg | addr_cfg.talk_only;
    end else if (set_receiver) begin
      receiver_reg <= 1'b1;
      speaker_reg <= 1'b0;
    end else if (set_speaker) begin
      speaker_reg <= 1'b1;
      receiver_reg <= 1'b0;
    end else begin
      receiver_reg <= receiver_reg & ~is_unl;
      speaker_reg <= speaker_reg & ~drop_speaker;
    end
  end

  // minor flag tracks which address was last received
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      minor_reg <= 1'b0;
    end else if (hard_clr | ~dual_prim) begin
      minor_reg <= 1'b0;
    end else if (mode_dual & (my_listen | my_talk)) begin
      minor_reg <= ~hit_major;
    end else if (mode_ext3 & (set_receiver | set_speaker)) begin
      minor_reg <= prim_minor_reg;
    end
  end

  // address state byte assembled from live flags
  logic [7:0] ads_byte;
  always_comb begin
    ads_byte = 8'h00;
    ads_byte[ADS_CTRL_POS] = ~(ctrl_idle | ctrl_addressed);
    ads_byte[ADS_ATN_POS] = atn_n_reg; // zero means attention asserted
    ads_byte[ADS_POLL_POS] = poll_mode_reg;
    ads_byte[ADS_LPRI_POS] = listen_prim_reg;
    ads_byte[ADS_TPRI_POS] = talk_prim_reg;
    ads_byte[ADS_LISTEN_POS] = receiver_reg;
    ads_byte[ADS_TALK_POS] = speaker_reg;
    ads_byte[ADS_MINOR_POS] = minor_reg;
  end

  // readback of the poll status register shows the outstanding flag in bit 6
  wire logic [7:0] poll_read = {status_reg[STATUS_TOP_POS], outstanding_reg, status_reg[5:0]};
  wire logic [7:0] rd_mux = sel_poll ? poll_read : (sel_ads ? ads_byte : 8'h00);

  // read data registered one cycle after the strobe, held until the next read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else if (reg_req.rd) begin
      rd_data_reg <= rd_mux;
    end
  end

  // poll byte on the bus carries the request state in bit 6
  logic [7:0] poll_byte_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      poll_byte_reg <= 8'h00;
    end else begin
      poll_byte_reg <= {status_reg[STATUS_TOP_POS], sr_next != SR_NEG, status_reg[5:0]};
    end
  end

  assign rd_data = rd_data_reg;
  assign poll_byte = poll_byte_reg;
  assign poll_byte_valid = poll_valid_reg;
  assign srq_oe = srq_reg;
endmodule : poll_addr_status

// ===== tb/gpib_ctl_model.sv
// behavioural bus controller that sends commands and takes the poll byte
`timescale 1ns/1ps
module gpib_ctl_model (
  input wire logic mclk,
  output logic cmd_strobe,
  output logic [7:0] cmd_byte,
  output logic atn_n_pin,
  output logic poll_byte_taken,
  input wire logic poll_byte_valid
);
  // idle bus: attention released, no strobe
  initial begin
    cmd_strobe = 1'b0;
    cmd_byte = 8'h00;
    atn_n_pin = 1'b1;
    poll_byte_taken = 1'b0;
  end
  // one command under attention; bit 7 carries junk the device must ignore
  task automatic send_cmd(input logic [6:0] c, input logic junk);
    @(negedge mclk);
    atn_n_pin = 1'b0;
    cmd_strobe = 1'b1;
    cmd_byte = {junk, c};
    @(negedge mclk);
    cmd_strobe = 1'b0;
    cmd_byte = ~cmd_byte; // stale byte never looks valid
  endtask : send_cmd
  // standby and listen, wait bounded, then take after a stall
  task automatic take_poll(input int stall, output logic ok);
    ok = 1'b0;
    @(negedge mclk);
    atn_n_pin = 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge mclk);
      ok = poll_byte_valid;
    end
    repeat (stall) @(negedge mclk);
    poll_byte_taken = 1'b1;
    @(negedge mclk);
    poll_byte_taken = 1'b0;
  endtask : take_poll
endmodule : gpib_ctl_model

// ===== tb/poll_addr_status_properties.sv
// port-level checks of the poll and address status block
`timescale 1ns/1ps
module poll_addr_status_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input poll_addr_pkg::reg_req_s reg_req,
  input wire logic [7:0] rd_data,
  input wire logic chip_reset,
  input poll_addr_pkg::addr_cfg_s addr_cfg,
  input wire logic ctrl_idle,
  input wire logic ctrl_addressed,
  input wire logic atn_n_pin,
  input wire logic [7:0] poll_byte,
  input wire logic poll_byte_valid,
  input wire logic srq_oe
);
  import poll_addr_pkg::*;
  logic [7:0] shadow_reg; // last status written
  logic dual_reg; // dual primary mode seen since a reset
  wire wr_ps = reg_req.wr && reg_req.addr == POLL_STATUS_OFS;
  wire rd_ps = reg_req.rd && reg_req.addr == POLL_STATUS_OFS;
  wire rd_as = reg_req.rd && reg_req.addr == ADDRESS_STATE_OFS;
  wire rd_xx = reg_req.rd && !rd_ps && !rd_as;
  // shadow of the written status; chip reset wipes it like the device
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= 8'h00;
      dual_reg <= 1'b0;
    end else begin
      shadow_reg <= chip_reset ? 8'h00 : (wr_ps ? reg_req.wdata : shadow_reg);
      dual_reg <= addr_cfg.mode[0] | (dual_reg & !chip_reset);
    end
  end
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_role_read: assert property (rd_as |=> rd_data[7] == !$past(ctrl_idle || ctrl_addressed))
    else $error("role bit wrong");
  a_atn_level: assert property (rd_as && $stable(atn_n_pin) && $past(atn_n_pin, 2) == atn_n_pin
    |=> rd_data[6] == $past(atn_n_pin)) else $error("attention bit wrong");
  a_talk_listen_excl: assert property (rd_as |=> !(rd_data[1] && rd_data[2]))
    else $error("talk and listen both set");
  a_minor_zero: assert property (rd_as && !dual_reg |=> !rd_data[0])
    else $error("minor flag outside dual mode");
  a_request_outstanding_on_write: assert property (wr_ps && reg_req.wdata[6] && !chip_reset ##1 !chip_reset ##1 rd_ps
    |=> rd_data[6]) else $error("outstanding flag not set");
  a_srq_request: assert property (wr_ps && reg_req.wdata[6] && !chip_reset ##1 !poll_byte_valid && !chip_reset
    |=> srq_oe) else $error("service request not driven");
  a_no_srq_polled: assert property (poll_byte_valid [*3] |-> !srq_oe)
    else $error("service request while polled");
  // the poll byte register lags the stored status by one edge
  a_poll_status: assert property (poll_byte_valid |-> poll_byte[7] == $past(shadow_reg[7])
    && poll_byte[5:0] == $past(shadow_reg[5:0])) else $error("poll byte status wrong");
  a_chip_clear: assert property (chip_reset |=> ##1 !srq_oe && !poll_byte_valid)
    else $error("chip reset left poll state");
  a_unmapped_zero: assert property (rd_xx |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  c_polled: cover property (poll_byte_valid ##1 !poll_byte_valid);
  c_srq: cover property (srq_oe ##1 !srq_oe);
  c_minor: cover property (rd_as ##1 rd_data[0]);
endmodule : poll_addr_status_properties
bind poll_addr_status poll_addr_status_properties poll_addr_status_properties_i (.mclk(mclk), .rst_n(rst_n),
  .reg_req(reg_req), .rd_data(rd_data), .chip_reset(chip_reset), .addr_cfg(addr_cfg), .ctrl_idle(ctrl_idle),
  .ctrl_addressed(ctrl_addressed), .atn_n_pin(atn_n_pin), .poll_byte(poll_byte),
  .poll_byte_valid(poll_byte_valid), .srq_oe(srq_oe));

// ===== tb/tb_poll_addr_status.sv
// self-checking bench for the poll and address status block
`timescale 1ns/1ps
module tb_poll_addr_status;
  import poll_addr_pkg::*;
  typedef struct packed { logic [7:0] val; logic [7:0] mask; } note_s;
  logic mclk, rst_n, chip_reset, soft_reset_bit, ctrl_idle, ctrl_addressed, sec_accept, sec_reject;
  logic cmd_strobe, atn_n_pin, poll_byte_taken, poll_byte_valid, srq_oe, rd_was, tk_was, ok;
  logic [7:0] cmd_byte, rd_data, poll_byte, pb_cap, rnd, st;
  reg_req_s reg_req;
  addr_cfg_s addr_cfg;
  note_s notes[$]; // expected results, oldest first
  int miscompares, samples_checked;
  // steps: mode, command, pulses {soft,reject,accept,chip}, expected state, mask
  logic [31:0] steps [18] = '{32'h145002bf, 32'h125004bf, 32'h14a003bf, 32'h145002bf, 32'h12a005bf,
    32'h000100bf, 32'h04a000bf, 32'h045000bf, 32'h245008bf, 32'h263002b7, 32'h225010b5, 32'h263004a7,
    32'h300100bf, 32'h32a010be, 32'h300205a7, 32'h345008aa, 32'h30040002, 32'h100100bf};
  poll_addr_status poll_addr_status_i (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data),
    .chip_reset(chip_reset), .soft_reset_bit(soft_reset_bit), .addr_cfg(addr_cfg), .ctrl_idle(ctrl_idle),
    .ctrl_addressed(ctrl_addressed), .atn_n_pin(atn_n_pin), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte),
    .sec_accept(sec_accept), .sec_reject(sec_reject), .poll_byte_taken(poll_byte_taken),
    .poll_byte(poll_byte), .poll_byte_valid(poll_byte_valid), .srq_oe(srq_oe));
  gpib_ctl_model gpib_ctl_model_i (.mclk(mclk), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte),
    .atn_n_pin(atn_n_pin), .poll_byte_taken(poll_byte_taken), .poll_byte_valid(poll_byte_valid));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // compare a result against the oldest note
  task automatic chk(input string what, input logic [7:0] seen);
    note_s n;
    n = notes.pop_front();
    samples_checked++;
    if ((seen & n.mask) !== n.val) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, n.val, seen);
    end
  endtask : chk
  // direct level check, used where no result event exists
  task automatic see(input string what, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask : see
  // one register access; a read notes its expected byte under mask
  task automatic reg_op(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge mclk);
    reg_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    if (!wr) notes.push_back('{val: d & m, mask: m});
    @(negedge mclk);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : reg_op
  task automatic pulse(input logic [3:0] sel);
    @(negedge mclk);
    {soft_reset_bit, sec_reject, sec_accept, chip_reset} = sel;
    @(negedge mclk);
    {soft_reset_bit, sec_reject, sec_accept, chip_reset} = 4'h0;
  endtask : pulse
  task automatic cmd(input logic [6:0] c);
    rnd = lfsr(rnd);
    gpib_ctl_model_i.send_cmd(c, rnd[0]);
  endtask : cmd
  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // results land on a rising edge; capture there, compare half a cycle on
  always @(posedge mclk) begin
    rd_was <= reg_req.rd;
    tk_was <= poll_byte_taken;
    pb_cap <= poll_byte;
  end
  always @(negedge mclk) begin
    if (rd_was) chk("rd_data", rd_data);
    if (tk_was) chk("poll_byte", pb_cap);
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    {rst_n, chip_reset, soft_reset_bit, sec_accept, sec_reject, ctrl_addressed} = 6'h00;
    ctrl_idle = 1'b1;
    rnd = 8'h5a;
    reg_req = '0;
    addr_cfg = '{mode: MODE_DUAL, talk_only: 1'b0, listen_only: 1'b0, major_addr: 5'h05,
      minor_addr: 5'h0a, second_addr: 5'h03};
    repeat (4) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    reg_op(1'b0, POLL_STATUS_OFS, 8'h00, 8'hff);
    reg_op(1'b0, 12'h11a, 8'h00, 8'hff);
    for (int i = 0; i < 4; i++) begin
      {ctrl_idle, ctrl_addressed} = i[1:0];
      reg_op(1'b0, ADDRESS_STATE_OFS, {i == 0, 7'h40}, 8'hff);
    end
    {ctrl_idle, ctrl_addressed} = 2'b10;
    foreach (steps[k]) begin
      addr_cfg.mode = steps[k][29:28];
      if (steps[k][27:20] != 8'h00) cmd(steps[k][26:20]);
      if (steps[k][19:16] != 4'h0) pulse(steps[k][19:16]);
      reg_op(1'b0, ADDRESS_STATE_OFS, steps[k][15:8], steps[k][7:0]);
    end
    rnd = lfsr(rnd);
    st = rnd | 8'h40;
    reg_op(1'b1, POLL_STATUS_OFS, st, 8'h00);
    reg_op(1'b0, POLL_STATUS_OFS, st, 8'hff);
    see("srq_oe", 1'b1, srq_oe);
    cmd({GRP_TALK, 5'h05});
    cmd(CMD_POLL_ENABLE);
    reg_op(1'b0, ADDRESS_STATE_OFS, 8'h22, 8'hbf);
    notes.push_back('{val: st, mask: 8'hff});
    gpib_ctl_model_i.take_poll(3, ok);
    see("poll_byte_valid", 1'b1, ok);
    see("srq_oe", 1'b0, srq_oe);
    cmd(CMD_POLL_DISABLE);
    repeat (4) @(negedge mclk);
    reg_op(1'b0, POLL_STATUS_OFS, st & 8'hbf, 8'hff);
    reg_op(1'b0, ADDRESS_STATE_OFS, 8'h02, 8'hff);
    see("srq_oe", 1'b0, srq_oe);
    cmd(CMD_POLL_ENABLE);
    pulse(4'h8);
    reg_op(1'b0, ADDRESS_STATE_OFS, 8'h02, 8'hbf);
    pulse(4'h1);
    reg_op(1'b0, POLL_STATUS_OFS, 8'h00, 8'hff);
    addr_cfg = '{mode: MODE_ONLY, talk_only: 1'b0, listen_only: 1'b1, default: '0};
    reg_op(1'b0, ADDRESS_STATE_OFS, 8'h04, 8'hbf);
    addr_cfg.listen_only = 1'b0;
    pulse(4'h1);
    addr_cfg.talk_only = 1'b1;
    reg_op(1'b0, ADDRESS_STATE_OFS, 8'h02, 8'hbf);
    addr_cfg.talk_only = 1'b0;
    pulse(4'h1);
    reg_op(1'b0, ADDRESS_STATE_OFS, 8'h00, 8'hbf);
    repeat (2) @(negedge mclk);
    final_report();
  end
endmodule : tb_poll_addr_status
